// ==== shared/sla_pkg.sv ====
// Package for the serial link alignment and alarm block
package sla_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PREEMPH = 8'h04;
    localparam logic [7:0] REG_ALARM_STATUS_BITS = 8'h08;
    localparam logic [7:0] REG_ALARM_MASK_BITS = 8'h0c;
    localparam logic [7:0] REG_LINK_STATE = 8'h10;

    // Control field positions
    localparam int CTRL_LINK_EN = 0;
    localparam int CTRL_CODING_64 = 1;
    localparam int CTRL_SUBCLASS1 = 2;
    localparam int CTRL_CAL_SEL = 3;
    localparam logic [3:0] CTRL_RESET = 4'h4;

    // Alarm status bit positions; lane bits start at ALM_LANE_BASE
    localparam int ALM_CPLL = 0;
    localparam int ALM_SPLL = 1;
    localparam int ALM_NOT_DATA = 2;
    localparam int ALM_SYSREF = 3;
    localparam int ALM_CLK_UPSET = 4;
    localparam int ALM_LANE_BASE = 8;
    localparam logic [31:0] ALARM_MASK_BITS_RESET = 32'h0000_0000;

    // Link state register field positions
    localparam int LS_STATE_LSB = 0;
    localparam int LS_SUMMARY = 4;
    localparam logic [3:0] PREEMPH_RESET = 4'h0;

    // 64B/66B multiblock layout
    localparam logic [7:0] BLOCKS_PER_MB = 8'h20;
    localparam logic [31:0] SH_STREAM = 32'h80e8_8888;
    localparam logic [4:0] EOEMB_POS = 5'h16;
    localparam logic [7:0] MB_PER_EMB = 8'h01;
    localparam logic [2:0] ILAS_MULTIFRAMES = 3'h4;

    // Input synchroniser pin indices
    localparam int PIN_SYSREF = 0;
    localparam int PIN_SYNC_N = 1;
    localparam int PIN_CPLL = 2;
    localparam int PIN_SPLL = 3;
    localparam int PIN_COUNT = 4;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CGS = 2'b01,
        ST_ILAS = 2'b10,
        ST_DATA = 2'b11
    } sla_state_t;
endpackage : sla_pkg

// ==== logic/sla_top.sv ====
// Transmit-side link control: LMFC/LEMC timing, link states, sync headers, alarms
//
// Functional notes
// RULE_01: In 64B/66B no lane alignment sequence is sent; receiver aligns otherwise.
// RULE_02: Receiver, 8B/10B: buffer from alignment sequence, release all at delay point.
// RULE_03: Receiver, 64B/66B: full alignment first, buffering from next extended multiblock.
// RULE_04: Receiver releases at first release point after all lanes buffer.
// RULE_05: Receiver release point is LEMC edge plus delay, clear of variation.
// RULE_06: Each block opens with sync header 01 or 10.
// RULE_07: Receiver restarts block alignment after several header errors in a window.
// RULE_08: Receiver checks pilot 00001 at multiblock tail; repeated misses restart.
// RULE_09: Receiver restarts extended alignment after repeated wrong end flags.
// RULE_10: After lost alignment the system reapplies SYSREF to restore LEMC.
// RULE_11: Serializer pre-emphasis follows the programmed level field.
// RULE_12: Software changes link parameters only while link enable is zero.
// RULE_13: Link enable zero resets link logic, powers down serializers, gates clocks.
// RULE_14: Captured SYSREF resets LMFC in 8B/10B, LEMC in 64B/66B.
// RULE_15: Receiver release point needs margin or latency jumps one period.
// RULE_16: Receiver release delay counts frame clocks; zero releases on edge.
// RULE_17: Release chance each period, only after all lanes; delay may exceed.
// RULE_18: Subclass 0 ignores SYSREF; LMFC/LEMC self-generated with arbitrary phase.
// RULE_19: In 8B/10B the receiver SYNC starts code group sync and ILAS.
// RULE_20: Six alarms: two PLL unlocks, not data, SYSREF realign, upset, FIFO.
// RULE_21: Each alarm bit stays set until written with one.
// RULE_22: Unmasked alarms show in summary; calibration pin may follow alarm.
// RULE_23: End-of-extended-multiblock flag is one only on final multiblock.
// RULE_24: One multiblock per extended multiblock, so the flag is always set.
// RULE_25: Lane FIFO pointer upset sets lane alarm; enable toggle resets FIFO.
// RULE_26: Summary and alarm pin are OR of unmasked status bits, each clock.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module sla_top
    import sla_pkg::*;
#(
    parameter int LANES = 4,
    parameter int PE_W = 4,
    parameter logic [7:0] FRAMES_PER_MF = 8'h20
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from outside the clock domain
    input wire logic sysref,
    input wire logic sync_n,
    input wire logic cpll_locked,
    input wire logic spll_locked,
    // Internal monitors on mclk
    input wire logic clock_upset,
    input wire logic [LANES-1:0] lane_fifo_error,
    input wire logic cal_done,
    // Link side
    output logic link_clk_en,
    output logic ser_powerdown,
    output logic fifo_reset,
    output logic [PE_W-1:0] serializer_preemphasis_level,
    output logic [1:0] sync_header,
    output logic block_start,
    output logic lemc_edge,
    output logic cgs_active,
    output logic ilas_active,
    output logic data_active,
    // Alarm outputs
    output logic alarm_summary,
    output logic cal_status_pin
);
    localparam int ALM_W = ALM_LANE_BASE + LANES;

    logic [3:0] ctrl_q;
    logic [PE_W-1:0] pe_q;
    logic [ALM_W-1:0] alarm_status_bits_q;
    logic [ALM_W-1:0] alarm_status_bits_d;
    logic [ALM_W-1:0] alarm_mask_bits_q;
    logic [PIN_COUNT-1:0] pin_s1_q;
    logic [PIN_COUNT-1:0] pin_s2_q;
    logic [PIN_COUNT-1:0] pin_s3_q;
    logic [PIN_COUNT-1:0] pin_q;
    logic sysref_prev_q;
    logic [7:0] mf_cnt_q;
    logic [2:0] ilas_cnt_q;
    sla_state_t state_q;
    logic [1:0] sync_header_q;
    logic block_start_q;
    logic lemc_edge_q;
    logic alarm_q;
    logic cal_pin_q;

    logic link_enable;
    logic coding_64;
    logic subclass1;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] wdata_m;
    logic addr_ok;
    logic sysref_edge;
    logic [7:0] mf_len;
    logic mf_wrap;
    logic [4:0] blk_idx;
    logic sh_bit;
    logic [ALM_W-1:0] events;
    logic [31:0] rd_mux;

    function automatic logic [31:0] strb_to_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_to_mask

    assign link_enable = ctrl_q[CTRL_LINK_EN];
    assign coding_64 = ctrl_q[CTRL_CODING_64];
    assign subclass1 = ctrl_q[CTRL_SUBCLASS1];

    // APB access, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign wmask = strb_to_mask(pstrb);
    assign wdata_m = pwdata & wmask;
    assign addr_ok = (paddr == REG_CTRL) | (paddr == REG_PREEMPH) |
                     (paddr == REG_ALARM_STATUS_BITS) | (paddr == REG_ALARM_MASK_BITS) |
                     (paddr == REG_LINK_STATE);
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == REG_CTRL) begin
            ctrl_q <= (ctrl_q & ~wmask[3:0]) | wdata_m[3:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pe_q <= PE_W'(PREEMPH_RESET);
        end else if (wr_en && paddr == REG_PREEMPH) begin
            pe_q <= (pe_q & ~wmask[PE_W-1:0]) | wdata_m[PE_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_mask_bits_q <= ALARM_MASK_BITS_RESET[ALM_W-1:0];
        end else if (wr_en && paddr == REG_ALARM_MASK_BITS) begin
            alarm_mask_bits_q <= (alarm_mask_bits_q & ~wmask[ALM_W-1:0]) | wdata_m[ALM_W-1:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            REG_CTRL: rd_mux[3:0] = ctrl_q;
            REG_PREEMPH: rd_mux[PE_W-1:0] = pe_q;
            REG_ALARM_STATUS_BITS: rd_mux[ALM_W-1:0] = alarm_status_bits_q;
            REG_ALARM_MASK_BITS: rd_mux[ALM_W-1:0] = alarm_mask_bits_q;
            REG_LINK_STATE: begin
                rd_mux[LS_STATE_LSB +: 2] = state_q;
                rd_mux[LS_SUMMARY] = alarm_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= {spll_locked, cpll_locked, sync_n, sysref};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_q[gi] <= 1'b0;
                end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sysref_prev_q <= 1'b0;
        end else begin
            sysref_prev_q <= pin_q[PIN_SYSREF];
        end
    end

    // Subclass 0 or disabled link ignores SYSREF
    assign sysref_edge = pin_q[PIN_SYSREF] & ~sysref_prev_q & subclass1 & link_enable; // RULE_18

    // LMFC/LEMC counter; LEMC spans one multiblock of fixed length
    assign mf_len = coding_64 ? BLOCKS_PER_MB * MB_PER_EMB : FRAMES_PER_MF; // RULE_24
    assign mf_wrap = (mf_cnt_q == mf_len - 8'h01);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mf_cnt_q <= 8'h00;
        end else if (!link_enable || sysref_edge) begin
            mf_cnt_q <= 8'h00; // RULE_13 RULE_14
        end else if (mf_wrap) begin
            mf_cnt_q <= 8'h00;
        end else begin
            mf_cnt_q <= mf_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lemc_edge_q <= 1'b0;
        end else begin
            lemc_edge_q <= link_enable & (mf_cnt_q == 8'h00);
        end
    end

    // Link state sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
            ilas_cnt_q <= 3'h0;
        end else if (!link_enable) begin
            state_q <= ST_OFF; // RULE_13
            ilas_cnt_q <= 3'h0;
        end else if (coding_64) begin
            state_q <= ST_DATA; // RULE_01
            ilas_cnt_q <= 3'h0;
        end else if (!pin_q[PIN_SYNC_N]) begin
            state_q <= ST_CGS; // RULE_19
            ilas_cnt_q <= 3'h0;
        end else begin
            unique case (state_q)
                ST_OFF: state_q <= ST_CGS;
                ST_CGS: begin
                    if (mf_wrap) begin
                        state_q <= ST_ILAS; // RULE_19
                    end
                end
                ST_ILAS: begin
                    if (mf_wrap) begin
                        if (ilas_cnt_q == ILAS_MULTIFRAMES - 3'h1) begin
                            state_q <= ST_DATA;
                        end
                        ilas_cnt_q <= ilas_cnt_q + 3'h1;
                    end
                end
                ST_DATA: state_q <= ST_DATA;
            endcase
        end
    end

    // Sync header stream for 64B/66B blocks
    assign blk_idx = mf_cnt_q[4:0];
    assign sh_bit = (blk_idx == EOEMB_POS) ? 1'b1 : SH_STREAM[blk_idx]; // RULE_23 RULE_24

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_header_q <= 2'h0;
            block_start_q <= 1'b0;
        end else if (!link_enable || !coding_64) begin
            sync_header_q <= 2'h0;
            block_start_q <= 1'b0;
        end else begin
            sync_header_q <= {~sh_bit, sh_bit}; // RULE_06
            block_start_q <= 1'b1;
        end
    end

    // Alarm events; set wins over a write-one clear
    always_comb begin
        events = '0;
        events[ALM_CPLL] = ~pin_q[PIN_CPLL];
        events[ALM_SPLL] = ~pin_q[PIN_SPLL];
        events[ALM_NOT_DATA] = (state_q != ST_DATA);
        events[ALM_SYSREF] = sysref_edge & (mf_cnt_q != 8'h00) & ~mf_wrap;
        events[ALM_CLK_UPSET] = clock_upset & link_enable;
        events[ALM_LANE_BASE +: LANES] = lane_fifo_error & {LANES{link_enable}}; // RULE_25
    end

    always_comb begin
        alarm_status_bits_d = alarm_status_bits_q;
        if (wr_en && paddr == REG_ALARM_STATUS_BITS) begin
            alarm_status_bits_d = alarm_status_bits_q & ~wdata_m[ALM_W-1:0]; // RULE_21
        end
        alarm_status_bits_d = alarm_status_bits_d | events; // RULE_20
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_status_bits_q <= '0;
        end else begin
            alarm_status_bits_q <= alarm_status_bits_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= 1'b0;
            cal_pin_q <= 1'b0;
        end else begin
            alarm_q <= |(alarm_status_bits_q & ~alarm_mask_bits_q); // RULE_22 RULE_26
            cal_pin_q <= ctrl_q[CTRL_CAL_SEL] ? |(alarm_status_bits_q & ~alarm_mask_bits_q)
                                              : cal_done; // RULE_22
        end
    end

    // Link side outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serializer_preemphasis_level <= '0;
        end else begin
            serializer_preemphasis_level <= pe_q; // RULE_11
        end
    end

    assign link_clk_en = link_enable; // RULE_13
    assign ser_powerdown = ~link_enable; // RULE_13
    assign fifo_reset = ~link_enable; // RULE_25
    assign sync_header = sync_header_q;
    assign block_start = block_start_q;
    assign lemc_edge = lemc_edge_q;
    assign cgs_active = (state_q == ST_CGS);
    assign ilas_active = (state_q == ST_ILAS);
    assign data_active = (state_q == ST_DATA);
    assign alarm_summary = alarm_q;
    assign cal_status_pin = cal_pin_q;
endmodule : sla_top

// ==== bench/sla_rx_model.sv ====
// Receiver-side model: resync request, SYSREF pulses and buffer release
`timescale 1ns/1ps
module sla_rx_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bench requests and link status
    input wire logic want_sync,
    input wire logic sysref_req,
    input wire logic lemc_edge,
    input wire logic data_active,
    // Pins toward the transmitter, and the release flag to the bench
    output logic sync_n,
    output logic sysref,
    output logic released
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_n <= 1'b1;
            sysref <= 1'b0;
            released <= 1'b0;
        end else begin
            sync_n <= !want_sync;
            sysref <= sysref_req;
            // Release on the period edge itself, once all lanes flow
            released <= data_active && (released || lemc_edge);
        end
    end
endmodule : sla_rx_model

// ==== bench/sla_checker.sv ====
// Assertions on the link control block ports
`timescale 1ns/1ps
module sla_checker
    import sla_pkg::*;
#(
    parameter int PE_W = 4
) (
    // Clock, reset and bus
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // Link side
    input wire logic link_clk_en,
    input wire logic ser_powerdown,
    input wire logic fifo_reset,
    input wire logic [PE_W-1:0] serializer_preemphasis_level,
    input wire logic [1:0] sync_header,
    input wire logic block_start,
    input wire logic lemc_edge,
    input wire logic cgs_active,
    input wire logic ilas_active,
    input wire logic data_active
);
    logic [5:0] gap_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Cycles since the last period edge, zero while disabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) gap_q <= 6'h00;
        else if (!link_clk_en) gap_q <= 6'h00;
        else if (lemc_edge) gap_q <= 6'h01;
        else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
    end
    a_gate_follow: assert property (
        link_clk_en == !ser_powerdown && fifo_reset == ser_powerdown)
        else $error("link gating outputs disagree");
    a_quiet_off: assert property (
        !link_clk_en && $past(!link_clk_en) |-> sync_header == 2'b00 && !block_start)
        else $error("headers while disabled");
    a_header_form: assert property (block_start |-> sync_header inside {2'b01, 2'b10})
        else $error("sync header without transition");
    a_no_align: assert property (block_start |-> !cgs_active && !ilas_active)
        else $error("alignment states in block mode");
    a_one_state: assert property ($onehot0({cgs_active, ilas_active, data_active}))
        else $error("several link states at once");
    a_stream_head: assert property (block_start && lemc_edge |-> sync_header == 2'b10)
        else $error("stream start header wrong");
    a_pilot_tail: assert property (
        block_start && !lemc_edge && gap_q inside {[6'd27:6'd30]} |-> sync_header == 2'b10)
        else $error("pilot zeros wrong");
    a_eoemb_set: assert property (
        block_start && !lemc_edge && gap_q == 6'd22 |-> sync_header == 2'b01)
        else $error("end flag not set");
    a_edge_period: assert property (link_clk_en |-> gap_q <= 6'd34)
        else $error("period edge missing");
    a_preemph_copy: assert property (
        psel && penable && pwrite && paddr == REG_PREEMPH && pstrb[0] |->
        ##2 serializer_preemphasis_level == $past(pwdata[PE_W-1:0], 2))
        else $error("preemphasis level not applied");
    c_edge_block: cover property (block_start && lemc_edge);
    c_ilas_data: cover property (ilas_active ##1 data_active);
    c_cgs: cover property (cgs_active);
endmodule : sla_checker

bind sla_top sla_checker #(.PE_W(PE_W)) u_chk (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .link_clk_en,
    .ser_powerdown, .fifo_reset, .serializer_preemphasis_level, .sync_header,
    .block_start, .lemc_edge, .cgs_active, .ilas_active, .data_active
);

// ==== bench/tb.sv ====
// Self-checking bench: bus, link outputs and alarms
`timescale 1ns/1ps
module tb;
    import sla_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, hit, saw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] pstrb, lane_fifo_error, serializer_preemphasis_level;
    logic [1:0] sync_header;
    logic sysref, sync_n, cpll_locked, spll_locked, clock_upset, cal_done;
    logic link_clk_en, ser_powerdown, fifo_reset, block_start, lemc_edge;
    logic cgs_active, ilas_active, data_active, alarm_summary, cal_status_pin;
    logic want_sync, sysref_req, released;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h86aa2d18;
    int lane;
    int hdr_bad, emb_bad, idx;
    sla_top dut (
        .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .sysref, .sync_n, .cpll_locked, .spll_locked,
        .clock_upset, .lane_fifo_error, .cal_done, .link_clk_en, .ser_powerdown,
        .fifo_reset, .serializer_preemphasis_level, .sync_header, .block_start,
        .lemc_edge, .cgs_active, .ilas_active, .data_active, .alarm_summary,
        .cal_status_pin
    );
    sla_rx_model rx (
        .mclk, .rst_n, .want_sync, .sysref_req, .lemc_edge, .data_active, .sync_n,
        .sysref, .released
    );
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Pulse SYSREF mid-period and note whether a period edge follows
    task automatic sref(output logic h);
        h = 1'b0;
        for (int k = 0; k < 40 && lemc_edge !== 1'b1; k++) @(posedge mclk);
        repeat (6) @(posedge mclk);
        sysref_req <= 1'b1;
        for (int k = 0; k < 14; k++) begin
            @(posedge mclk);
            if (k == 3) sysref_req <= 1'b0;
            if (lemc_edge === 1'b1) h = 1'b1;
        end
    endtask : sref
    initial begin
        {rst_n, psel, penable, pwrite, cpll_locked, spll_locked} = 6'h00;
        {clock_upset, cal_done, want_sync, sysref_req} = 4'h0;
        {paddr, pwdata, lane_fifo_error} = 44'h0;
        pstrb = 4'hf;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        cpll_locked <= 1'b1;
        spll_locked <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rd, {28'h0, CTRL_RESET});
        apb(1'b0, REG_ALARM_MASK_BITS, 32'h0);
        chk("mask", rd, ALARM_MASK_BITS_RESET);
        apb(1'b1, 8'h14, 32'hffff_ffff);
        chk("slverr", {31'h0, err}, 32'h1);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("status", rd, 32'h7);
        apb(1'b1, REG_ALARM_STATUS_BITS, 32'h3);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("w1c", rd, 32'h4);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            apb(1'b1, REG_PREEMPH, v);
            apb(1'b0, REG_PREEMPH, 32'h0);
            chk("pe_reg", rd, {28'h0, v[3:0]});
            chk("pe_pin", {28'h0, serializer_preemphasis_level}, {28'h0, v[3:0]});
        end
        chk("gate", {29'h0, link_clk_en, ser_powerdown, fifo_reset}, 32'h3);
        apb(1'b1, REG_CTRL, 32'h7);
        repeat (4) @(posedge mclk);
        chk("on", {28'h0, link_clk_en, ser_powerdown, fifo_reset, data_active}, 32'h9);
        apb(1'b0, REG_LINK_STATE, 32'h0);
        chk("state", rd, 32'h13);
        apb(1'b1, REG_ALARM_STATUS_BITS, 32'hffff_ffff);
        repeat (70) @(posedge mclk);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("clear", {rd[30:0], alarm_summary}, 32'h0);
        chk("release", {31'h0, released}, 32'h1);
        // Receiver view of the block stream: header form and end flag position
        hdr_bad = 0;
        emb_bad = 0;
        idx = -100;
        repeat (64) begin
            @(negedge mclk);
            idx = (lemc_edge === 1'b1) ? 0 : idx + 1;
            if (!(sync_header inside {2'b01, 2'b10})) hdr_bad++;
            if (idx == 22 && sync_header !== 2'b01) emb_bad++;
        end
        chk("hdr_bad", hdr_bad, 0);
        chk("eoemb_bad", emb_bad, 0);
        sref(hit);
        chk("sref_edge", {31'h0, hit}, 32'h1);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("realign", rd, 32'h8);
        apb(1'b1, REG_CTRL, 32'hf);
        apb(1'b1, REG_ALARM_MASK_BITS, 32'h8);
        repeat (3) @(posedge mclk);
        chk("masked", {30'h0, alarm_summary, cal_status_pin}, 32'h0);
        apb(1'b1, REG_ALARM_MASK_BITS, 32'h0);
        repeat (3) @(posedge mclk);
        chk("unmasked", {30'h0, alarm_summary, cal_status_pin}, 32'h3);
        cal_done <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h7);
        repeat (3) @(posedge mclk);
        chk("cal_pin", {31'h0, cal_status_pin}, 32'h1);
        apb(1'b1, REG_ALARM_STATUS_BITS, 32'hffff_ffff);
        lane = $unsigned($random(seed)) % 4;
        clock_upset <= 1'b1;
        lane_fifo_error <= 4'h1 << lane;
        @(posedge mclk);
        {clock_upset, lane_fifo_error, cpll_locked} <= 6'h00;
        repeat (6) @(posedge mclk);
        cpll_locked <= 1'b1;
        repeat (6) @(posedge mclk);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("events", rd, 32'h11 | (32'h100 << lane));
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (2) @(posedge mclk);
        chk("fifo_rst", {31'h0, fifo_reset}, 32'h1);
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b1, REG_ALARM_STATUS_BITS, 32'hffff_ffff);
        sref(hit);
        chk("sc0_edge", {31'h0, hit}, 32'h0);
        apb(1'b0, REG_ALARM_STATUS_BITS, 32'h0);
        chk("sc0", rd, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0);
        want_sync <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h5);
        repeat (8) @(posedge mclk);
        chk("cgs", {29'h0, cgs_active, sync_header}, 32'h4);
        want_sync <= 1'b0;
        saw = 1'b0;
        for (int k = 0; k < 400 && data_active !== 1'b1; k++) begin
            @(posedge mclk);
            if (ilas_active === 1'b1) saw = 1'b1;
        end
        chk("ilas", {30'h0, saw, data_active}, 32'h3);
        finish_test();
    end
endmodule : tb
